// ---- src/pcs_config_register_space.sv ----
`default_nettype none

module pcs_config_register_space
    import pcs_regs_pkg::*;
#(
    parameter bit COMBINED = 1'b1,
    parameter logic [31:0] BUILD_IDENT = 32'h0000_0000,
    parameter logic [15:0] CORE_VERSION = 16'h0001,
    parameter int TIMEOUT_LIMIT = READ_TIMEOUT_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rdvalid,
    output logic reg_busy,
    input wire logic [15:0] pcs_status_in,
    input wire logic [15:0] peer_ability_in,
    input wire logic [15:0] autoneg_expansion_info_in,
    input wire logic core_ready,
    output logic [15:0] control_out,
    output logic [15:0] local_ability_out,
    output logic [20:0] link_timer_out,
    output logic [15:0] if_select_out
);

    // The arbitrary default of the identifier and version is neutral.
    localparam logic [7:0] BASE = COMBINED ? COMBINED_BASE : 8'h00;
    localparam int WD_BOUND = TIMEOUT_LIMIT + 2;

    typedef struct packed {
        rd_state_t rstate;
        logic [4:0] pend_idx;
        logic busy;
        logic rdvalid;
        logic [15:0] rdata;
        logic [15:0] control;
        logic [15:0] ability;
        logic [15:0] scratch;
        logic [15:0] if_select;
        logic [14:0] timer_lo;
        logic [4:0] timer_hi;
        logic wd_off;
        logic expiry;
    } regs_t;

    regs_t st_r;
    regs_t st_nxt;

    // Returns the hit flag and word index of a bus address.
    function automatic logic [5:0] decode(input logic [7:0] a);
        logic hit;
        hit = (a[7:5] == BASE[7:5]);
        return {hit, a[4:0]};
    endfunction

    // Words sourced live from the sublayer may stall and time out.
    function automatic logic is_core_word(input logic [4:0] idx);
        return (idx == OFS_STATUS) || (idx == OFS_PEER_ABILITY) ||
            (idx == OFS_EXPANSION);
    endfunction

    logic [5:0] dec;
    logic rd_take;
    logic wr_take;
    logic [4:0] sel_idx;
    logic [15:0] rd_word;
    logic wd_run;
    logic wd_expired;

    assign dec = decode(reg_addr);
    assign rd_take = reg_rd && (st_r.rstate == RD_IDLE);
    assign wr_take = reg_wr && !reg_rd && (st_r.rstate == RD_IDLE);
    assign sel_idx = (st_r.rstate == RD_WAIT) ? st_r.pend_idx : dec[4:0];
    assign wd_run = (st_r.rstate == RD_WAIT) && !st_r.wd_off &&
        !core_ready;

    read_watchdog #(
        .LIMIT(TIMEOUT_LIMIT)
    ) u_watchdog (
        .mclk(mclk),
        .rstn(rstn),
        .run(wd_run),
        .expired(wd_expired)
    );

    always_comb begin
        rd_word = 16'h0000;
        unique case (sel_idx)
            OFS_CONTROL: rd_word = st_r.control;
            OFS_STATUS: rd_word = pcs_status_in;
            OFS_IDENT_UPPER: rd_word = BUILD_IDENT[31:16];
            OFS_IDENT_LOWER: rd_word = BUILD_IDENT[15:0];
            OFS_LOCAL_ABILITY: rd_word = st_r.ability;
            OFS_PEER_ABILITY: rd_word = peer_ability_in;
            OFS_EXPANSION: rd_word = autoneg_expansion_info_in;
            // No extended status registers exist, so the word is zero.
            OFS_EXTENDED_STATE: rd_word = 16'h0000;
            OFS_SCRATCH: rd_word = st_r.scratch;
            OFS_VERSION: rd_word = CORE_VERSION;
            OFS_INTERVAL_LOW: rd_word = {st_r.timer_lo, 1'b0};
            OFS_INTERVAL_HIGH: rd_word = {11'h000, st_r.timer_hi};
            OFS_IF_SELECT: rd_word = st_r.if_select;
            OFS_WATCHDOG_OFF: rd_word = {15'h0000, st_r.wd_off};
            OFS_EXPIRY_FLAG: rd_word = {15'h0000, st_r.expiry};
            // Unsupported page and reserved words read as zero.
            default: rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdvalid = 1'b0;
        unique case (st_r.rstate)
            RD_IDLE: begin
                if (rd_take) begin
                    if (dec[5] && is_core_word(dec[4:0])) begin
                        st_nxt.rstate = RD_WAIT;
                        st_nxt.busy = 1'b1;
                        st_nxt.pend_idx = dec[4:0];
                    end else begin
                        st_nxt.rdvalid = 1'b1;
                        st_nxt.rdata = dec[5] ? rd_word : 16'h0000;
                        if (dec[5] && dec[4:0] == OFS_EXPIRY_FLAG) begin
                            st_nxt.expiry = 1'b0;
                        end
                    end
                end else if (wr_take && dec[5]) begin
                    // Words without a case item drop the write.
                    case (dec[4:0])
                        OFS_CONTROL: begin
                            st_nxt.control = reg_wdata[15:0];
                        end
                        OFS_LOCAL_ABILITY: begin
                            st_nxt.ability = reg_wdata[15:0];
                        end
                        OFS_SCRATCH: begin
                            st_nxt.scratch = reg_wdata[15:0];
                        end
                        OFS_INTERVAL_LOW: begin
                            st_nxt.timer_lo = reg_wdata[15:1];
                        end
                        OFS_INTERVAL_HIGH: begin
                            st_nxt.timer_hi = reg_wdata[4:0];
                        end
                        OFS_IF_SELECT: begin
                            st_nxt.if_select = reg_wdata[15:0];
                        end
                        OFS_WATCHDOG_OFF: begin
                            st_nxt.wd_off = reg_wdata[0];
                        end
                        default: begin
                            st_nxt.rstate = RD_IDLE;
                        end
                    endcase
                end
            end
            RD_WAIT: begin
                if (core_ready) begin
                    st_nxt.rstate = RD_IDLE;
                    st_nxt.busy = 1'b0;
                    st_nxt.rdvalid = 1'b1;
                    st_nxt.rdata = rd_word;
                    st_nxt.expiry = 1'b0;
                end else if (wd_expired) begin
                    st_nxt.rstate = RD_IDLE;
                    st_nxt.busy = 1'b0;
                    st_nxt.rdvalid = 1'b1;
                    st_nxt.rdata = 16'h0000;
                    st_nxt.expiry = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r.rstate <= RD_IDLE;
            st_r.pend_idx <= 5'h00;
            st_r.busy <= 1'b0;
            st_r.rdvalid <= 1'b0;
            st_r.rdata <= 16'h0000;
            st_r.control <= CONTROL_RESET;
            st_r.ability <= ABILITY_RESET;
            st_r.scratch <= SCRATCH_RESET;
            st_r.if_select <= IF_SELECT_RESET;
            st_r.timer_lo <= LINK_TIMER_RESET[15:1];
            st_r.timer_hi <= LINK_TIMER_RESET[20:16];
            st_r.wd_off <= 1'b0;
            st_r.expiry <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = {16'h0000, st_r.rdata};
    assign reg_rdvalid = st_r.rdvalid;
    assign reg_busy = st_r.busy;
    assign control_out = st_r.control;
    assign local_ability_out = st_r.ability;
    assign link_timer_out = {st_r.timer_hi, st_r.timer_lo, 1'b0};
    assign if_select_out = st_r.if_select;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    property p_upper_zero;
        reg_rdvalid |-> reg_rdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper half of read data not zero");

    property p_scratch_back;
        (wr_take && reg_addr == BASE + {3'b000, OFS_SCRATCH}) ##1 !wr_take ##1
            (rd_take && reg_addr == BASE + {3'b000, OFS_SCRATCH})
            |=> reg_rdvalid && reg_rdata[15:0] == $past(reg_wdata[15:0], 3);
    endproperty
    a_scratch_back: assert property (p_scratch_back)
        else $error("scratch did not return last write");

    property p_ident_upper;
        rd_take && reg_addr == BASE + {3'b000, OFS_IDENT_UPPER}
            |=> reg_rdvalid && reg_rdata[15:0] == BUILD_IDENT[31:16];
    endproperty
    a_ident_upper: assert property (p_ident_upper)
        else $error("identifier upper half wrong");

    property p_unsupported_zero;
        rd_take && dec[5] && dec[4:0] >= OFS_LOCAL_EXTRA_PAGE &&
            dec[4:0] <= OFS_LEADER_STATE |=> reg_rdata[15:0] == 16'h0000;
    endproperty
    a_unsupported_zero: assert property (p_unsupported_zero)
        else $error("unsupported page word not zero");

    property p_page_write_drop;
        wr_take && dec[5] && dec[4:0] >= OFS_LOCAL_EXTRA_PAGE &&
            dec[4:0] <= OFS_LEADER_STATE |=> $stable(control_out) &&
            $stable(local_ability_out) && $stable(if_select_out) &&
            $stable(link_timer_out) && $stable(st_r.scratch) &&
            $stable(st_r.wd_off);
    endproperty
    a_page_write_drop: assert property (p_page_write_drop)
        else $error("write to unsupported page word took effect");

    property p_reserved_zero;
        rd_take && (!dec[5] || dec[4:0] >= OFS_RSVD_HIGH_FIRST ||
            (dec[4:0] >= OFS_RSVD_LOW_FIRST &&
            dec[4:0] <= OFS_RSVD_LOW_LAST)) |=> reg_rdata[15:0] == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved word not zero");

    property p_timer_high;
        wr_take && reg_addr == BASE + {3'b000, OFS_INTERVAL_HIGH}
            |=> link_timer_out[20:16] == $past(reg_wdata[4:0]) &&
            $stable(link_timer_out[15:0]);
    endproperty
    a_timer_high: assert property (p_timer_high)
        else $error("timer high bits not updated");

    property p_timer_low;
        wr_take && reg_addr == BASE + {3'b000, OFS_INTERVAL_LOW}
            |=> link_timer_out[15:0] == {$past(reg_wdata[15:1]), 1'b0} &&
            $stable(link_timer_out[20:16]);
    endproperty
    a_timer_low: assert property (p_timer_low)
        else $error("timer low bits not updated");

    property p_timer_bit0;
        link_timer_out[0] == 1'b0;
    endproperty
    a_timer_bit0: assert property (p_timer_bit0)
        else $error("timer bit 0 not zero");

    property p_wait_bounded;
        reg_busy && !st_r.wd_off |-> ##[1:WD_BOUND] reg_rdvalid;
    endproperty
    a_wait_bounded: assert property (p_wait_bounded)
        else $error("read not ended within timeout");

    property p_expiry_set;
        st_r.rstate == RD_WAIT && wd_expired && !core_ready
            |=> reg_rdvalid && st_r.expiry && reg_rdata[15:0] == 16'h0000;
    endproperty
    a_expiry_set: assert property (p_expiry_set)
        else $error("timeout did not set indication");

    property p_live_end;
        st_r.rstate == RD_WAIT && core_ready
            |=> reg_rdvalid && !reg_busy && !st_r.expiry;
    endproperty
    a_live_end: assert property (p_live_end)
        else $error("normal end of live read mishandled");

    property p_expiry_clear;
        rd_take && reg_addr == BASE + {3'b000, OFS_EXPIRY_FLAG}
            |=> !st_r.expiry && reg_rdata[0] == $past(st_r.expiry);
    endproperty
    a_expiry_clear: assert property (p_expiry_clear)
        else $error("indication not cleared by read");

    property p_watchdog_off;
        st_r.wd_off |-> !wd_expired;
    endproperty
    a_watchdog_off: assert property (p_watchdog_off)
        else $error("timeout fired while disabled");

    property p_control_write;
        wr_take && reg_addr == BASE + {3'b000, OFS_CONTROL}
            |=> control_out == $past(reg_wdata[15:0]);
    endproperty
    a_control_write: assert property (p_control_write)
        else $error("control write not taken");

    c_core_read: cover property (reg_busy ##1 core_ready ##1 reg_rdvalid);
    c_timeout: cover property (wd_expired ##1 st_r.expiry);
    c_flag_read: cover property (st_r.expiry ##0 rd_take &&
        dec[4:0] == OFS_EXPIRY_FLAG);
    c_scratch: cover property (wr_take && dec[4:0] == OFS_SCRATCH);
    c_slow_read: cover property (st_r.wd_off && reg_busy ##1 core_ready);

endmodule

`default_nettype wire

// ---- src/pcs_regs_pkg.sv ----
`default_nettype none

package pcs_regs_pkg;

    localparam logic [7:0] COMBINED_BASE = 8'h80;

    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h01;
    localparam logic [4:0] OFS_IDENT_UPPER = 5'h02;
    localparam logic [4:0] OFS_IDENT_LOWER = 5'h03;
    localparam logic [4:0] OFS_LOCAL_ABILITY = 5'h04;
    localparam logic [4:0] OFS_PEER_ABILITY = 5'h05;
    localparam logic [4:0] OFS_EXPANSION = 5'h06;
    localparam logic [4:0] OFS_LOCAL_EXTRA_PAGE = 5'h07;
    localparam logic [4:0] OFS_LEADER_STATE = 5'h0a;
    localparam logic [4:0] OFS_RSVD_LOW_FIRST = 5'h0b;
    localparam logic [4:0] OFS_RSVD_LOW_LAST = 5'h0e;
    localparam logic [4:0] OFS_EXTENDED_STATE = 5'h0f;
    localparam logic [4:0] OFS_SCRATCH = 5'h10;
    localparam logic [4:0] OFS_VERSION = 5'h11;
    localparam logic [4:0] OFS_INTERVAL_LOW = 5'h12;
    localparam logic [4:0] OFS_INTERVAL_HIGH = 5'h13;
    localparam logic [4:0] OFS_IF_SELECT = 5'h14;
    localparam logic [4:0] OFS_WATCHDOG_OFF = 5'h15;
    localparam logic [4:0] OFS_EXPIRY_FLAG = 5'h16;
    localparam logic [4:0] OFS_RSVD_HIGH_FIRST = 5'h17;

    localparam logic [15:0] CONTROL_RESET = 16'h1140;
    localparam logic [15:0] ABILITY_RESET = 16'h0000;
    localparam logic [15:0] IF_SELECT_RESET = 16'h0000;
    localparam logic [15:0] SCRATCH_RESET = 16'h0000;

    localparam int LINK_TIMER_W = 21;
    localparam int LINK_STEP_NS = 8;
    localparam int LINK_RESET_MS = 10;
    localparam int LINK_MAX_MS = 16;
    localparam logic [20:0] LINK_TIMER_RESET =
        21'(LINK_RESET_MS * 1000000 / LINK_STEP_NS);

    localparam int CLK_PERIOD_NS = 40;
    localparam int READ_TIMEOUT_NS = 2000;
    localparam int READ_TIMEOUT_CYCLES = READ_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_WAIT = 1'b1
    } rd_state_t;

endpackage

`default_nettype wire

// ---- src/read_watchdog.sv ----
`default_nettype none

// Counts cycles while a read waits on the sublayer and flags expiry.
module read_watchdog
    import pcs_regs_pkg::*;
#(
    parameter int LIMIT = READ_TIMEOUT_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic run,
    output logic expired
);

    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } wd_t;

    wd_t st_r;
    wd_t st_nxt;

    assign expired = run && (st_r.cnt == LAST);

    always_comb begin
        st_nxt = st_r;
        if (!run || expired) begin
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- testbench/host_model.sv ----
`default_nettype none

// Bus master on the register side: word addressed, one request at a time.
module host_model
    import pcs_regs_pkg::*;
(
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rdvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 32'h0;
    end

    // Word addressing: base plus offset, no scaling by four.
    function automatic logic [7:0] map(
        input logic [4:0] ofs);
        return COMBINED_BASE + 8'(ofs);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        // Released lines show garbage rather than the last value.
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    // Next read only after the answer, so nothing is silently dropped.
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output int lat);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        lat = -1;
        d = 32'h0;
        for (int i = 1; i < 100; i++) begin
            if (reg_rdvalid === 1'b1) begin
                d = reg_rdata;
                lat = i;
                break;
            end
            @(negedge mclk);
        end
    endtask
endmodule

`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none

`define CHK(nm, exp, got) \
    num_checks++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("unexpected %s exp %h got %h", nm, exp, got); \
    end

module tb;
    import pcs_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TL = 4;
    // Identifier and version values are arbitrary.
    localparam logic [31:0] IDENT = 32'h1234_5678;
    localparam logic [15:0] VERS = 16'h0203;

    logic mclk, rstn, reg_rd, reg_wr, reg_rdvalid, reg_busy, core_ready;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [15:0] pcs_status_in, peer_ability_in, autoneg_expansion_info_in;
    logic [15:0] control_out, local_ability_out, if_select_out;
    logic [20:0] link_timer_out;
    int err_count = 0;
    int num_checks = 0;
    int lat;

    pcs_config_register_space #(.COMBINED(1'b1), .BUILD_IDENT(IDENT),
        .CORE_VERSION(VERS), .TIMEOUT_LIMIT(TL)) DUT (
        .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdvalid(reg_rdvalid), .reg_busy(reg_busy),
        .pcs_status_in(pcs_status_in), .peer_ability_in(peer_ability_in),
        .autoneg_expansion_info_in(autoneg_expansion_info_in),
        .core_ready(core_ready), .control_out(control_out),
        .local_ability_out(local_ability_out),
        .link_timer_out(link_timer_out), .if_select_out(if_select_out));

    host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdvalid(reg_rdvalid));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic rd(input logic [4:0] ofs);
        host.rd(host.map(ofs), d, lat);
        if (lat < 0) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    task automatic rdc(input logic [4:0] ofs, input logic [31:0] exp);
        rd(ofs);
        `CHK($sformatf("word %h", ofs), exp, d)
    endtask

    task automatic wr(input logic [4:0] ofs, input logic [31:0] v);
        host.wr(host.map(ofs), v);
    endtask

    task automatic t_reset();
        rdc(OFS_CONTROL, 32'h0000_1140);
        rdc(OFS_LOCAL_ABILITY, 32'h0);
        rdc(OFS_INTERVAL_LOW, 32'h0000_12d0);
        rdc(OFS_INTERVAL_HIGH, 32'h0000_0013);
        `CHK("timer", 21'h1312d0, link_timer_out)
        rdc(OFS_WATCHDOG_OFF, 32'h0);
        rdc(OFS_EXPIRY_FLAG, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_rw();
        logic [4:0] ofs [4] = '{OFS_CONTROL, OFS_LOCAL_ABILITY, OFS_SCRATCH,
                                OFS_IF_SELECT};
        foreach (ofs[i]) begin
            wr(ofs[i], 32'hffff_5aa5);
            rdc(ofs[i], 32'h0000_5aa5);
        end
        `CHK("control", 16'h5aa5, control_out)
        `CHK("ability", 16'h5aa5, local_ability_out)
        `CHK("ifsel", 16'h5aa5, if_select_out)
        wr(OFS_WATCHDOG_OFF, 32'hffff_ffff);
        rdc(OFS_WATCHDOG_OFF, 32'h0000_0001);
        wr(OFS_WATCHDOG_OFF, 32'h0);
        $display("test rw done");
    endtask

    task automatic t_timer();
        wr(OFS_INTERVAL_LOW, 32'hffff_ffff);
        wr(OFS_INTERVAL_HIGH, 32'hffff_ffff);
        rdc(OFS_INTERVAL_LOW, 32'h0000_fffe);
        rdc(OFS_INTERVAL_HIGH, 32'h0000_001f);
        `CHK("timer", 21'h1ffffe, link_timer_out)
        $display("test timer done");
    endtask

    task automatic t_ro();
        for (int o = 2; o < 32; o++) begin
            if (o < 4 || (o > 6 && o < 16) || o == 17 || o > 22) begin
                wr(5'(o), 32'hffff_ffff);
            end
        end
        rdc(OFS_IDENT_UPPER, {16'h0, IDENT[31:16]});
        rdc(OFS_IDENT_LOWER, {16'h0, IDENT[15:0]});
        rdc(OFS_VERSION, {16'h0, VERS});
        for (int o = 7; o < 32; o++) begin
            if (o < 16 || o > 22) begin
                rdc(5'(o), 32'h0);
            end
        end
        host.rd(8'h20, d, lat);
        `CHK("unmapped", 32'h0, d)
        `CHK("unmapped_lat", 1, lat)
        host.wr(8'h00, 32'hffff_ffff);
        rdc(OFS_CONTROL, 32'h0000_5aa5);
        $display("test readonly done");
    endtask

    task automatic t_live();
        core_ready = 1'b1;
        rdc(OFS_STATUS, 32'h0000_c3a1);
        rdc(OFS_PEER_ABILITY, 32'h0000_4e21);
        rdc(OFS_EXPANSION, 32'h0000_0006);
        rdc(OFS_EXPIRY_FLAG, 32'h0);
        $display("test live done");
    endtask

    task automatic t_timeout();
        core_ready = 1'b0;
        rdc(OFS_STATUS, 32'h0);
        `CHK("tmo_lat", 1'b1, lat == TL + 1)
        rdc(OFS_EXPIRY_FLAG, 32'h1);
        rdc(OFS_EXPIRY_FLAG, 32'h0);
        wr(OFS_WATCHDOG_OFF, 32'h1);
        fork
            rdc(OFS_STATUS, 32'h0000_c3a1);
            begin
                repeat (20) @(negedge mclk);
                `CHK("busy_wait", 1'b1, reg_busy)
                core_ready = 1'b1;
            end
        join
        `CHK("slow_lat", 1'b1, lat >= 20)
        `CHK("busy_end", 1'b0, reg_busy)
        $display("test timeout done");
    endtask

    task automatic t_midreset();
        wr(OFS_SCRATCH, 32'h0000_a55a);
        @(negedge mclk);
        rstn = 1'b0;
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        `CHK("ctl_rst", CONTROL_RESET, control_out)
        `CHK("tmr_rst", LINK_TIMER_RESET, link_timer_out)
        rdc(OFS_SCRATCH, {16'h0000, SCRATCH_RESET});
        rdc(OFS_WATCHDOG_OFF, 32'h0);
        $display("test midreset done");
    endtask

    initial begin
        rstn = 1'b0;
        core_ready = 1'b1;
        pcs_status_in = 16'hc3a1;
        peer_ability_in = 16'h4e21;
        autoneg_expansion_info_in = 16'h0006;
        repeat (20) @(negedge mclk);
        rstn = 1'b1;
        t_reset();
        t_rw();
        t_timer();
        t_ro();
        t_live();
        t_timeout();
        t_midreset();
        tally_and_finish();
    end
endmodule

`default_nettype wire
